// file: sslsr_top.sv
// Sense and timeout reporting with framing for one start/stop line.
//
// What this block does
// RL1: Read or Inhibit started after a lost character flags C0 and runs on.
// RL2: Dial start with next-digit request on gives C2, remote connected C4.
// RL3: Modem ready rising before the last dial digit gives C5.
// RL4: Channel stop or program/protection check in receive gives C6, ends.
// RL5: Channel stop counts only when chained data is not in use.
// RL6: Halt during Read or Inhibit gives C7 and is no error.
// RL7: No timeout in Sense, No-op, Write, Break; timeout ends others now.
// RL8: Read times out if line never stayed quiet a character time.
// RL9: Read or Poll in control mode times out after three seconds.
// RL10: Read in text mode times out after the long timer.
// RL11: Modem ready or switched permanent-send carrier loss reports intervention instead.
// RL12: Dialer abandon gives E6 at Dial start and E7 during Dial.
// RL13: Switched Disable with modem ready still on after 25 s gives E8.
// RL14: Switched permanent-send Enable lacking both carrier and CTS gives E9.
// RL15: Break space longer than 25 s during Prepare gives ED.
// RL16: Line speed is chosen from seven rates by configuration.
// RL17: Each control character can be disabled and then passes as data.
// RL18: Carriage return and one free character may act as control.
// RL19: Lost data sets sense bit 6 with the cause in sense byte 1.
// RL20: An enabled end-of-transmission ends Read with unit exception.
// RL21: Each sent byte gets a start bit and one or two stop bits.
// RL22: Any sense bit raised, except by Halt, gives unit check in the ending status.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sslsr_top #(
	parameter int P_SEC_CYC = sslsr_pkg::SEC_CYC
) (
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_rst_n,
	input  wire logic [sslsr_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [31:0]                  i_wdata,
	input  wire logic                         i_wr,
	input  wire logic                         i_rd,
	output logic      [31:0]                  o_rdata,
	input  wire logic                         i_rx_line,
	input  wire logic                         i_modem_ready,
	input  wire logic                         i_carrier,
	input  wire logic                         i_cts,
	input  wire logic                         i_next_digit,
	input  wire logic                         i_remote_conn,
	input  wire logic                         i_abandon,
	input  wire logic                         i_rx_valid,
	input  wire logic [7:0]                   i_rx_char,
	input  wire logic                         i_rx_lost,
	input  wire logic                         i_last_digit,
	input  wire logic                         i_chan_stop,
	input  wire logic                         i_chain_data,
	input  wire logic                         i_prog_check,
	input  wire logic                         i_prot_check,
	input  wire logic                         i_halt,
	output logic                              o_tx_line,
	output logic                              o_cmd_end,
	output logic                              o_data_valid,
	output logic      [7:0]                   o_data
);
	import sslsr_pkg::*;

	typedef struct packed {
		logic [6:0]  s1;
		logic [6:0]  s2;
		logic [6:0]  prev;
		logic [31:0] tick;
		logic [18:0] baud;
		logic [3:0]  qbits;
		logic        qok;
		logic [5:0]  space;
		logic [5:0]  tsec;
		logic        trun;
		logic        lastd;
		logic        first;
		sslsr_cmd_t  cmd;
		logic        busy;
		logic [4:0]  st;
		logic [7:0]  sns0;
		logic [7:0]  sns1;
		logic [31:0] cfg;
		logic [10:0] tx_sh;
		logic [3:0]  tx_left;
		logic [18:0] tx_cnt;
		logic        tx_line;
		logic [31:0] rdata;
		logic        cmd_end;
		logic        dvalid;
		logic [7:0]  dbyte;
	} sslsr_state_t;

	sslsr_state_t q;
	sslsr_state_t n;
	logic [1:0]   rst_q;
	logic         rst_n;
	logic         rxl, rdy, car, cts, nxd, rmt, abn;
	logic         rdy_rise, abn_rise, sw, prts, text, sec_t, bit_t;
	logic [18:0]  div;
	logic [6:0]   cc_hit;
	logic         ctrl_hit, to_read;
	logic         fin, exc, halt, intv;
	logic [7:0]   ldc, toc;

	// The reset is released only after two clean edges of our own clock.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	assign rxl      = q.s2[PI_RX];
	assign rdy      = q.s2[PI_RDY];
	assign car      = q.s2[PI_CAR];
	assign cts      = q.s2[PI_CTS];
	assign nxd      = q.s2[PI_NXD];
	assign rmt      = q.s2[PI_RMT];
	assign abn      = q.s2[PI_ABN];
	assign rdy_rise = rdy && !q.prev[PI_RDY];
	assign abn_rise = abn && !q.prev[PI_ABN];
	assign sw       = q.cfg[CF_SW];
	assign prts     = q.cfg[CF_PRTS];
	assign text     = q.cfg[CF_TEXT];
	// RL16 speed select
	assign div      = sslsr_div(q.cfg[CF_SPD +: 3]);
	assign sec_t    = (q.tick == 32'(P_SEC_CYC - 1));
	assign bit_t    = (q.baud == div - 19'h1);

	// RL17 RL18 control match
	for (genvar g = 0; g < CC_N; g++) begin : g_cc
		if (g < 6) begin : g_std
			assign cc_hit[g] = q.cfg[CF_CCEN + g]
				&& (i_rx_char == CC_TAB[g*8 +: 8]);
		end else begin : g_free
			assign cc_hit[g] = q.cfg[CF_CCEN + g]
				&& (i_rx_char == q.cfg[CF_XCH +: 8]);
		end
	end
	assign ctrl_hit = |cc_hit;

	// RL8 RL9 RL10 read timers
	assign to_read = q.busy && (
		(!text && (q.cmd == CM_READ || q.cmd == CM_POLL)
			&& q.tsec >= TMO_CTRL_S)
		|| (q.cmd == CM_READ && q.tsec >= TMO_LONG_S
			&& (text || !q.qok)));

	always_comb begin
		n = q;
		fin = 1'b0;
		exc = 1'b0;
		halt = 1'b0;
		intv = 1'b0;
		ldc = 8'h00;
		toc = 8'h00;
		n.cmd_end = 1'b0;
		n.dvalid = 1'b0;
		n.first = 1'b0;
		n.rdata = 32'h0;
		n.s1 = {i_rx_line, i_modem_ready, i_carrier, i_cts,
			i_next_digit, i_remote_conn, i_abandon};
		n.s2 = q.s1;
		n.prev = q.s2;
		n.tick = sec_t ? 32'h0 : q.tick + 32'h1;
		n.baud = bit_t ? 19'h0 : q.baud + 19'h1;
		if (rxl != q.prev[PI_RX]) begin
			n.qbits = 4'h0;
		end else if (bit_t && q.qbits != CHAR_BITS) begin
			n.qbits = q.qbits + 4'h1;
		end
		if (q.qbits == CHAR_BITS) begin
			n.qok = 1'b1;
		end
		if (rxl) begin
			n.space = 6'h0;
		end else if (sec_t && q.space != 6'h3f) begin
			n.space = q.space + 6'h1;
		end
		if (sec_t && q.tsec != 6'h3f) begin
			n.tsec = q.tsec + 6'h1;
		end
		// RL17 pass as data
		if (i_rx_valid && !ctrl_hit) begin
			n.dvalid = 1'b1;
			n.dbyte = i_rx_char;
		end
		// RL21 start and stop bits
		if (q.tx_left != 4'h0) begin
			if (q.tx_cnt == div - 19'h1) begin
				n.tx_cnt = 19'h0;
				n.tx_sh = {1'b1, q.tx_sh[10:1]};
				n.tx_left = q.tx_left - 4'h1;
			end else begin
				n.tx_cnt = q.tx_cnt + 19'h1;
			end
		end
		n.tx_line = (q.tx_left != 4'h0) ? q.tx_sh[0] : 1'b1;

		if (q.busy) begin
			case (q.cmd)
				CM_READ, CM_INH, CM_POLL: begin
					// RL1 character lost before
					if (q.first && q.cmd != CM_POLL && i_rx_lost) begin
						ldc = LD_PRE;
					end
					// RL6 halt is no error
					if (i_halt && q.cmd != CM_POLL) begin
						ldc = LD_HALT;
						halt = 1'b1;
						fin = 1'b1;
					// RL4 RL5 stop and checks
					end else if ((i_chan_stop && !i_chain_data)
						|| i_prog_check || i_prot_check) begin
						ldc = LD_STOP;
						fin = 1'b1;
					// RL11 intervention instead
					end else if (!rdy || (sw && prts && !car)) begin
						intv = 1'b1;
						fin = 1'b1;
					end else if (to_read) begin
						toc = TO_READ;
						fin = 1'b1;
					// RL20 end of transmission
					end else if (q.cmd != CM_INH && i_rx_valid
						&& ctrl_hit) begin
						fin = 1'b1;
						exc = cc_hit[CC_EOT];
					end
				end
				CM_DIAL: begin
					if (i_last_digit) begin
						n.lastd = 1'b1;
					end
					// RL12 RL2 dial start
					if (q.first && abn) begin
						toc = TO_ABST;
						fin = 1'b1;
					end else if (q.first && nxd) begin
						ldc = LD_NXD;
						fin = 1'b1;
					end else if (q.first && rmt) begin
						ldc = LD_RMT;
						fin = 1'b1;
					// RL12 abandon later
					end else if (abn_rise) begin
						toc = TO_ABEX;
						fin = 1'b1;
					// RL3 ready too early
					end else if (rdy_rise && !q.lastd) begin
						ldc = LD_EARLY;
						fin = 1'b1;
					end else if (rdy && q.lastd) begin
						fin = 1'b1;
					end
				end
				CM_ENA: begin
					// RL14 enable timer
					if (sw && prts) begin
						if (!q.trun && rdy) begin
							n.trun = 1'b1;
							n.tsec = 6'h0;
						end else if (q.trun && (car || cts)) begin
							fin = 1'b1;
						end else if (q.trun && q.tsec >= TMO_LINE_S) begin
							toc = TO_ENA;
							fin = 1'b1;
						end
					end else if (rdy) begin
						fin = 1'b1;
					end
				end
				CM_DIS: begin
					// RL13 disable timer
					if (!sw || !rdy) begin
						fin = 1'b1;
					end else if (q.tsec >= TMO_LINE_S) begin
						toc = TO_DISC;
						fin = 1'b1;
					end
				end
				CM_PREP: begin
					// RL15 long break
					if (q.space > SPACE_MAX_S) begin
						toc = TO_SPACE;
						fin = 1'b1;
					end else if (i_rx_valid) begin
						fin = 1'b1;
					end
				end
				// RL7 these never time out
				default: fin = 1'b1;
			endcase
		end

		// RL19 lost data sense
		if (ldc != 8'h00) begin
			n.sns0[SNS_LOST] = 1'b1;
			n.sns1 = ldc;
		end
		if (toc != 8'h00) begin
			n.sns0[SNS_TMO] = 1'b1;
			n.sns1 = toc;
		end
		if (intv) begin
			n.sns0[SNS_INTV] = 1'b1;
		end
		// RL7 RL22 ending status
		if (fin) begin
			n.busy = 1'b0;
			n.cmd_end = 1'b1;
			n.st = 5'h0;
			n.st[ST_CE] = 1'b1;
			n.st[ST_CE + 1] = 1'b1;
			n.st[ST_UE] = exc;
			n.st[ST_UC] = (|q.sns0) || intv || (toc != 8'h00)
				|| (ldc != 8'h00 && !halt);
		end

		if (i_wr) begin
			if (i_addr == A_CFG) begin
				n.cfg = i_wdata;
			end else if (i_addr == A_CMD && !q.busy) begin
				n.busy = 1'b1;
				n.first = 1'b1;
				n.sns0 = 8'h00;
				n.sns1 = 8'h00;
				n.st = 5'h0;
				n.tsec = 6'h0;
				n.trun = 1'b0;
				n.lastd = 1'b0;
				n.qok = 1'b0;
				case (i_wdata[3:0])
					C_READ:  n.cmd = CM_READ;
					C_INH:   n.cmd = CM_INH;
					C_POLL:  n.cmd = CM_POLL;
					C_DIAL:  n.cmd = CM_DIAL;
					C_ENA:   n.cmd = CM_ENA;
					C_DIS:   n.cmd = CM_DIS;
					C_PREP:  n.cmd = CM_PREP;
					C_SENSE: n.cmd = CM_SENSE;
					C_NOOP:  n.cmd = CM_NOOP;
					C_WRITE: n.cmd = CM_WRITE;
					C_BREAK: n.cmd = CM_BREAK;
					default: begin
						n.busy = 1'b0;
						n.first = 1'b0;
					end
				endcase
			end else if (i_addr == A_TXD && q.tx_left == 4'h0) begin
				n.tx_sh = {2'h3, i_wdata[7:0], 1'b0};
				n.tx_left = q.cfg[CF_STOP2] ? 4'hb : 4'ha;
				n.tx_cnt = 19'h0;
			end
		end
		if (i_rd) begin
			if (i_addr == A_CFG) begin
				n.rdata = q.cfg;
			end else if (i_addr == A_CMD) begin
				n.rdata = {28'h0, q.cmd};
			end else if (i_addr == A_SNS) begin
				n.rdata = {16'h0, q.sns1, q.sns0};
			end else if (i_addr == A_STS) begin
				n.rdata = {26'h0, q.tx_left != 4'h0, q.st[4:1], q.busy};
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.cfg <= CFG_RST;
			q.tx_line <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign o_rdata      = q.rdata;
	assign o_tx_line    = q.tx_line;
	assign o_cmd_end    = q.cmd_end;
	assign o_data_valid = q.dvalid;
	assign o_data       = q.dbyte;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!rst_n);

	sequence rd_busy_s;
		q.busy && q.cmd == CM_READ;
	endsequence
	sequence halt_seen_s;
		rd_busy_s ##0 i_halt;
	endsequence
	sequence tx_start_s;
		i_wr && i_addr == A_TXD && q.tx_left == 4'h0;
	endsequence

	halt_ends_a: assert property ( // RL6
		halt_seen_s |=> !q.busy && q.sns1 == LD_HALT && q.cmd_end)
		else $error("Halt during read did not end with C7.");
	stop_ends_a: assert property ( // RL4
		rd_busy_s ##0 (!i_halt && i_chan_stop && !i_chain_data)
		|=> !q.busy && q.sns1 == LD_STOP && q.sns0[SNS_LOST])
		else $error("Channel stop did not end read with C6.");
	dial_early_a: assert property ( // RL3
		q.busy && q.cmd == CM_DIAL && !q.first && !abn_rise
		&& rdy_rise && !q.lastd |=> q.sns1 == LD_EARLY && !q.busy)
		else $error("Early modem ready in dial not flagged C5.");
	tmo_never_a: assert property ( // RL7
		q.cmd_end && q.cmd inside {CM_SENSE, CM_NOOP, CM_WRITE,
		CM_BREAK} |-> !q.sns0[SNS_TMO])
		else $error("Timeout flagged for a command that has none.");
	tmo_ends_a: assert property ( // RL7
		$rose(q.sns0[SNS_TMO]) |-> !q.busy && q.cmd_end)
		else $error("Timeout did not end the command.");
	space_break_a: assert property ( // RL15
		q.busy && q.cmd == CM_PREP && q.space > SPACE_MAX_S
		|=> q.sns1 == TO_SPACE && q.st[ST_UC])
		else $error("Long break in prepare not flagged ED.");
	disc_tmo_a: assert property ( // RL13
		q.busy && q.cmd == CM_DIS && sw && rdy
		&& q.tsec >= TMO_LINE_S |=> q.sns1 == TO_DISC)
		else $error("Disable timeout not flagged E8.");
	unit_check_a: assert property ( // RL22
		q.cmd_end && q.sns0[SNS_TMO] |-> q.st[ST_UC])
		else $error("Timeout sense without unit check.");
	tx_frame_a: assert property ( // RL21
		tx_start_s |-> ##2 !o_tx_line ##1 (q.tx_left != 4'h0))
		else $error("Transmit did not begin with a start bit.");

endmodule : sslsr_top
`default_nettype wire

// file: sslsr_pkg.sv
// Constants, types and the baud table of the line sense reporting block.
package sslsr_pkg;

	localparam int          CLK_HZ      = 25_000_000;
	localparam int          CLK_PER_NS  = 40;
	localparam int          SEC_S       = 1;
	localparam int          SEC_CYC     = CLK_HZ * SEC_S;
	localparam logic [3:0]  CHAR_BITS   = 4'ha;

	localparam logic [5:0]  TMO_LONG_S  = 6'h19;
	localparam logic [5:0]  TMO_CTRL_S  = 6'h03;
	localparam logic [5:0]  TMO_LINE_S  = 6'h19;
	localparam logic [5:0]  SPACE_MAX_S = 6'h19;

	localparam int          ADDR_W = 4;
	localparam logic [3:0]  A_CFG  = 4'h0;
	localparam logic [3:0]  A_CMD  = 4'h1;
	localparam logic [3:0]  A_TXD  = 4'h2;
	localparam logic [3:0]  A_SNS  = 4'h3;
	localparam logic [3:0]  A_STS  = 4'h4;

	localparam int          CF_SPD   = 0;
	localparam int          CF_STOP2 = 3;
	localparam int          CF_CCEN  = 4;
	localparam int          CF_XCH   = 11;
	localparam int          CF_SW    = 19;
	localparam int          CF_PRTS  = 20;
	localparam int          CF_TEXT  = 21;
	localparam logic [31:0] CFG_RST  = 32'h0000_01f0;

	localparam logic [3:0]  C_READ  = 4'h1;
	localparam logic [3:0]  C_INH   = 4'h2;
	localparam logic [3:0]  C_POLL  = 4'h3;
	localparam logic [3:0]  C_DIAL  = 4'h4;
	localparam logic [3:0]  C_ENA   = 4'h5;
	localparam logic [3:0]  C_DIS   = 4'h6;
	localparam logic [3:0]  C_PREP  = 4'h7;
	localparam logic [3:0]  C_SENSE = 4'h8;
	localparam logic [3:0]  C_NOOP  = 4'h9;
	localparam logic [3:0]  C_WRITE = 4'ha;
	localparam logic [3:0]  C_BREAK = 4'hb;

	localparam int          SNS_INTV = 1;
	localparam int          SNS_LOST = 6;
	localparam int          SNS_TMO  = 7;
	localparam logic [7:0]  LD_PRE   = 8'hc0;
	localparam logic [7:0]  LD_NXD   = 8'hc2;
	localparam logic [7:0]  LD_RMT   = 8'hc4;
	localparam logic [7:0]  LD_EARLY = 8'hc5;
	localparam logic [7:0]  LD_STOP  = 8'hc6;
	localparam logic [7:0]  LD_HALT  = 8'hc7;
	localparam logic [7:0]  TO_READ  = 8'he0;
	localparam logic [7:0]  TO_ABST  = 8'he6;
	localparam logic [7:0]  TO_ABEX  = 8'he7;
	localparam logic [7:0]  TO_DISC  = 8'he8;
	localparam logic [7:0]  TO_ENA   = 8'he9;
	localparam logic [7:0]  TO_SPACE = 8'hed;

	localparam int          ST_BUSY = 0;
	localparam int          ST_CE   = 1;
	localparam int          ST_UE   = 3;
	localparam int          ST_UC   = 4;

	localparam int          CC_N   = 7;
	localparam int          CC_EOT = 4;
	localparam logic [47:0] CC_TAB = 48'hb0_20_c8_61_89_a1;

	localparam int          PI_RX  = 6;
	localparam int          PI_RDY = 5;
	localparam int          PI_CAR = 4;
	localparam int          PI_CTS = 3;
	localparam int          PI_NXD = 2;
	localparam int          PI_RMT = 1;
	localparam int          PI_ABN = 0;

	typedef enum logic [3:0] {
		CM_NONE, CM_READ, CM_INH, CM_POLL, CM_DIAL, CM_ENA, CM_DIS,
		CM_PREP, CM_SENSE, CM_NOOP, CM_WRITE, CM_BREAK
	} sslsr_cmd_t;

	function automatic logic [18:0] sslsr_div(input logic [2:0] s);
		case (s)
			3'h0:    sslsr_div = 19'(CLK_HZ * 10 / 750);
			3'h1:    sslsr_div = 19'(CLK_HZ * 10 / 1100);
			3'h2:    sslsr_div = 19'(CLK_HZ * 10 / 1345);
			3'h3:    sslsr_div = 19'(CLK_HZ * 10 / 3000);
			3'h4:    sslsr_div = 19'(CLK_HZ * 10 / 6000);
			3'h5:    sslsr_div = 19'(CLK_HZ * 10 / 12000);
			default: sslsr_div = 19'(CLK_HZ * 10 / 24000);
		endcase
	endfunction : sslsr_div

endpackage : sslsr_pkg

// file: sslsr_partner.sv
// Modem, dialer and remote terminal model facing one start/stop line.
`timescale 1ns/1ps
`default_nettype none
module sslsr_partner (
	input  wire logic       i_clk_sys,
	input  wire logic       i_tx_line,
	input  wire logic       i_last_digit,
	input  wire logic [6:0] i_set,
	output logic            o_rx_line,
	output logic      [5:0] o_modem
);
	logic [6:0] seen = 7'h00;
	logic       ans  = 1'h0;
	int         cnt  = 0;

	// The remote terminal echoes what it hears; a held break wins.
	assign o_rx_line = i_tx_line & ~i_set[6];
	// Bits are ready, carrier, cts, next digit, remote, abandon.
	assign o_modem = i_set[5:0] | {ans, 3'h0, ans, 1'h0};

	// The dialer answers a few cycles late, so the block must wait for it.
	always @(posedge i_clk_sys) begin
		seen <= i_set;
		if (i_last_digit === 1'h1) begin
			cnt <= 6;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		if (cnt == 1) begin
			ans <= 1'h1;
		end else if (seen != i_set) begin
			ans <= 1'h0;
		end
	end
endmodule : sslsr_partner
`default_nettype wire

// file: test_sslsr_top.sv
// Self-checking bench for the line sense reporting block.
`timescale 1ns/1ps
`default_nettype none
module test_sslsr_top;
	import sslsr_pkg::*;
	// Short seconds keep every timer within a brief run.
	localparam int SEC = 20;
	logic        i_clk_sys = 1'h0;
	logic        i_rst_n   = 1'h0;
	logic [3:0]  i_addr    = 4'h0;
	logic [31:0] i_wdata   = 32'h0;
	logic        i_wr      = 1'h0;
	logic        i_rd      = 1'h0;
	logic [5:0]  pv        = 6'h00;
	logic [7:0]  i_rx_char = 8'h00;
	logic        i_rx_lost = 1'h0;
	logic        i_chain   = 1'h0;
	logic [6:0]  kn        = 7'h38;
	logic [31:0] o_rdata;
	logic [31:0] rv;
	logic [7:0]  o_data;
	logic [5:0]  pm;
	logic        rx_line;
	logic        o_tx_line;
	logic        o_cmd_end;
	logic        o_data_valid;
	int          err_total  = 0;
	int          n_compared = 0;
	int          waited     = 0;

	always #20 i_clk_sys = ~i_clk_sys;

	sslsr_top #(.P_SEC_CYC(SEC)) i_sslsr_top (
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_rx_line(rx_line), .i_modem_ready(pm[5]), .i_carrier(pm[4]),
		.i_cts(pm[3]), .i_next_digit(pm[2]), .i_remote_conn(pm[1]),
		.i_abandon(pm[0]), .i_rx_valid(pv[5]), .i_rx_char(i_rx_char),
		.i_rx_lost(i_rx_lost), .i_last_digit(pv[4]), .i_chan_stop(pv[3]),
		.i_chain_data(i_chain), .i_prog_check(pv[2]),
		.i_prot_check(pv[1]), .i_halt(pv[0]), .o_tx_line(o_tx_line),
		.o_cmd_end(o_cmd_end), .o_data_valid(o_data_valid), .o_data(o_data)
	);

	sslsr_partner i_sslsr_partner (
		.i_clk_sys(i_clk_sys), .i_tx_line(o_tx_line),
		.i_last_digit(pv[4]), .i_set(kn), .o_rx_line(rx_line), .o_modem(pm)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'h0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge i_clk_sys);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'h0;
		#1 rv = o_rdata;
	endtask : rd

	task automatic cmd(input logic [31:0] cfg, input logic [3:0] c);
		wr(A_CFG, cfg);
		wr(A_CMD, {28'h0, c});
	endtask : cmd

	task automatic pul(input int k, input logic [7:0] c);
		@(posedge i_clk_sys);
		pv[k] <= 1'h1;
		i_rx_char <= c;
		@(posedge i_clk_sys);
		pv[k] <= 1'h0;
	endtask : pul

	// Modem inputs pass two flops, so give them time to be seen.
	task automatic ln(input logic [6:0] v);
		@(posedge i_clk_sys);
		kn <= v;
		repeat (4) @(posedge i_clk_sys);
	endtask : ln

	task automatic fin(input logic [15:0] s, input logic [5:0] t);
		waited = 0;
		#1;
		while (o_cmd_end !== 1'h1 && waited < 2000) begin
			@(posedge i_clk_sys);
			#1 waited++;
		end
		chk({31'h0, o_cmd_end}, 32'h1);
		rd(A_SNS);
		chk(rv, {16'h0, s});
		rd(A_STS);
		chk(rv, {26'h0, t});
	endtask : fin

	task automatic t_ctl;
		logic [31:0] c;
		c = (CFG_RST & ~32'h100) | 32'h600 | (32'h55 << CF_XCH);
		cmd(CFG_RST, C_READ);
		pul(5, 8'h20);
		fin(16'h0, 6'h0e);
		cmd(c, C_READ);
		pul(5, 8'h20);
		#1 chk({o_data_valid, o_data}, 32'h120);
		pul(5, 8'h55);
		fin(16'h0, 6'h06);
		cmd(c, C_READ);
		pul(5, 8'hb0);
		fin(16'h0, 6'h06);
	endtask : t_ctl

	task automatic t_abort;
		cmd(CFG_RST, C_READ);
		pul(0, 8'h0);
		fin(16'hc740, 6'h06);
		@(posedge i_clk_sys);
		i_rx_lost <= 1'h1;
		i_chain <= 1'h1;
		cmd(CFG_RST, C_READ);
		pul(3, 8'h0);
		i_rx_lost <= 1'h0;
		rd(A_STS);
		chk(rv, 32'h1);
		rd(A_SNS);
		chk(rv, 32'hc040);
		@(posedge i_clk_sys);
		i_chain <= 1'h0;
		pul(3, 8'h0);
		fin(16'hc640, 6'h16);
		cmd(CFG_RST, C_INH);
		pul(2, 8'h0);
		fin(16'hc640, 6'h16);
		cmd(CFG_RST, C_POLL);
		pul(1, 8'h0);
		fin(16'hc640, 6'h16);
	endtask : t_abort

	task automatic t_dial;
		logic [6:0]  v [3] = '{7'h1c, 7'h1a, 7'h19};
		logic [15:0] s [3] = '{16'hc240, 16'hc440, 16'he680};
		for (int k = 0; k < 3; k++) begin
			ln(v[k]);
			cmd(CFG_RST, C_DIAL);
			fin(s[k], 6'h16);
		end
		ln(7'h18);
		cmd(CFG_RST, C_DIAL);
		// The end pulse follows three edges later, so watch for it at once.
		@(posedge i_clk_sys);
		kn <= 7'h19;
		fin(16'he780, 6'h16);
		ln(7'h18);
		cmd(CFG_RST, C_DIAL);
		@(posedge i_clk_sys);
		kn <= 7'h38;
		fin(16'hc540, 6'h16);
		ln(7'h18);
		cmd(CFG_RST, C_DIAL);
		pul(4, 8'h0);
		fin(16'h0, 6'h06);
	endtask : t_dial

	task automatic t_tmo;
		logic [3:0] q [4] = '{C_SENSE, C_NOOP, C_WRITE, C_BREAK};
		ln(7'h38);
		cmd(CFG_RST, C_READ);
		fin(16'he080, 6'h16);
		// The seconds tick runs free, so a timer may end one tick early.
		chk({31'h0, waited > 40 && waited < 62}, 32'h1);
		cmd(CFG_RST | (32'h1 << CF_TEXT), C_READ);
		fin(16'he080, 6'h16);
		chk({31'h0, waited > 480 && waited < 502}, 32'h1);
		cmd(CFG_RST, C_READ);
		@(posedge i_clk_sys);
		kn <= 7'h18;
		fin(16'h0002, 6'h16);
		for (int k = 0; k < 4; k++) begin
			cmd(CFG_RST, q[k]);
			fin(16'h0, 6'h06);
		end
		ln(7'h38);
		cmd(CFG_RST | 32'h80000, C_DIS);
		fin(16'he880, 6'h16);
		ln(7'h00);
		cmd(CFG_RST | 32'h180000, C_ENA);
		ln(7'h20);
		fin(16'he980, 6'h16);
		ln(7'h38);
		cmd(CFG_RST, C_PREP);
		ln(7'h78);
		fin(16'hed80, 6'h16);
		chk({31'h0, waited > 480}, 32'h1);
		ln(7'h38);
	endtask : t_tmo

	// Only the start bit and first data bit are timed; a whole frame at
	// this rate would take far longer than the rest of the run.
	task automatic t_tx;
		int div;
		div = CLK_HZ * 10 / 24000;
		wr(A_CFG, CFG_RST | 32'h6);
		wr(A_TXD, 32'ha5);
		repeat (2) @(posedge i_clk_sys);
		#1 chk({31'h0, o_tx_line}, 32'h0);
		// The start bit stands div cycles from the edge after the write.
		repeat (div - 2) @(posedge i_clk_sys);
		#1 chk({31'h0, o_tx_line}, 32'h0);
		@(posedge i_clk_sys);
		#1 chk({31'h0, o_tx_line}, 32'h1);
	endtask : t_tx

	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	initial begin
		repeat (4) @(posedge i_clk_sys);
		i_rst_n <= 1'h1;
		repeat (3) @(posedge i_clk_sys);
		rd(A_CFG);
		chk(rv, CFG_RST);
		rd(A_SNS);
		chk(rv, 32'h0);
		t_ctl();
		t_abort();
		t_dial();
		t_tmo();
		t_tx();
		results();
	end

	initial begin
		#1_600_000;
		err_total++;
		results();
	end
endmodule : test_sslsr_top
`default_nettype wire
